// ==== core/scd_clock_control.sv ====
`timescale 1ns/10ps
module scd_clock_control
  import scd_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clock fabric status
  input  wire logic        monitor_fail,
  input  wire logic        switch_done,
  input  wire logic        irq_any,
  input  wire logic        pll_lock,
  // oscillator controls
  output logic             clock_fail_flag,
  output logic             fail_trap,
  output logic             switch_request,
  output logic [2:0]       new_source_select,
  output logic [2:0]       current_source_select,
  // divider controls
  output logic             doze_enable,
  output logic [2:0]       doze_ratio,
  output logic [2:0]       fast_rc_postscaler,
  output logic [3:0]       pll_prescaler,
  output logic [7:0]       pll_feedback_value,
  output logic [5:0]       fast_rc_trim,
  output logic [1:0]       vco_output_divider,
  output logic [2:0]       first_post_divider,
  output logic [2:0]       second_post_divider
);

  logic       cf_reg;
  logic       trap_reg;
  logic       swr_reg;
  logic [2:0] new_source_select_reg;
  logic [2:0] target_reg;
  logic [2:0] current_source_select_reg;
  logic       roi_reg;
  logic [2:0] doze_reg;
  logic       doze_enable_reg;
  logic [2:0] ratio_reg;
  logic [2:0] frc_reg;
  logic [3:0] pre_reg;
  logic [7:0] fbd_reg;
  logic [5:0] tun_reg;
  logic [1:0] vco_reg;
  logic [2:0] p1_reg;
  logic [2:0] p2_reg;

  // bus phase decode
  wire setup_ph = psel & ~penable;
  wire acc_done = psel & penable & pready;
  wire wr_done  = acc_done & pwrite;
  wire hit_osc  = (paddr == OSC_ADDR);
  wire hit_div  = (paddr == DIV_ADDR);
  wire hit_fbd  = (paddr == FBD_ADDR);
  wire hit_tun  = (paddr == TUN_ADDR);
  wire hit_pdiv = (paddr == PDIV_ADDR);
  wire mapped   = hit_osc | hit_div | hit_fbd | hit_tun | hit_pdiv;

  wire div_wr_hi  = wr_done & hit_div & pstrb[LANE_HI];
  wire div_wr_lo  = wr_done & hit_div & pstrb[LANE_LO];
  wire fbd_wr     = wr_done & hit_fbd & pstrb[LANE_LO];
  wire tun_wr     = wr_done & hit_tun & pstrb[LANE_LO];
  wire pdiv_wr_hi = wr_done & hit_pdiv & pstrb[LANE_HI];
  wire pdiv_wr_lo = wr_done & hit_pdiv & pstrb[LANE_LO];

  // per-lane unlock of the oscillator register
  wire [LANES-1:0] osc_lane_wr;
  wire [LANES-1:0] lane_open;
  wire [LANES-1:0] osc_apply;

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign osc_lane_wr[gi] = wr_done & hit_osc & pstrb[gi];
      assign osc_apply[gi]   = osc_lane_wr[gi] & lane_open[gi];
      scd_unlock #(
        .KEY1 (KEY_FIRST[gi]),
        .KEY2 (KEY_SECOND[gi])
      ) u_unlock (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .lane_wr   (osc_lane_wr[gi]),
        .other_acc (acc_done & ~osc_lane_wr[gi]),
        .wr_byte   (pwdata[gi*BYTE_W +: BYTE_W]),
        .open      (lane_open[gi])
      );
    end
  endgenerate

  // oscillator control next state
  wire sw_cf_set  = osc_apply[LANE_LO] & pwdata[OSC_CF_BIT];
  wire sw_cf_clr  = osc_apply[LANE_LO] & ~pwdata[OSC_CF_BIT];
  wire sw_swr_set = osc_apply[LANE_LO] & pwdata[OSC_SWR_BIT];
  wire swr_done   = swr_reg & switch_done;

  // failure event wins over a clearing write
  wire       cf_next   = monitor_fail | sw_cf_set | (cf_reg & ~sw_cf_clr);
  wire       trap_next = monitor_fail | sw_cf_set;
  wire       swr_next  = sw_swr_set | (swr_reg & ~switch_done);
  wire [2:0] new_source_select_next = osc_apply[LANE_HI] ? pwdata[OSC_NEW_SOURCE_SELECT_LSB +: 3] : new_source_select_reg;
  wire [2:0] current_source_select_next = swr_done ? scd_map_source(new_source_select_reg) : current_source_select_reg;

  // clock divider next state
  wire       roi_next  = div_wr_hi ? pwdata[DIV_ROI_BIT] : roi_reg;
  wire [2:0] doze_next = (div_wr_hi & ~doze_enable_reg) ?
                         pwdata[DIV_DOZE_LSB +: 3] : doze_reg;
  wire       doze_enable_wr  = div_wr_hi ?
                         (pwdata[DIV_DOZE_ENABLE_BIT] & (doze_next != DOZE_1TO1)) :
                         doze_enable_reg;
  wire       doze_enable_next = (irq_any & roi_reg) ? 1'b0 : doze_enable_wr;
  wire [2:0] ratio_next = doze_enable_next ? doze_next : DOZE_1TO1;
  wire [2:0] frc_next   = div_wr_hi ? pwdata[DIV_FRC_LSB +: 3] : frc_reg;
  wire [3:0] pre_next   = div_wr_lo ? pwdata[DIV_PRE_LSB +: 4] : pre_reg;

  // read views
  wire [15:0] osc_view = (16'(current_source_select_reg) << OSC_CURRENT_SOURCE_SELECT_LSB) |
                         (16'(new_source_select_reg) << OSC_NEW_SOURCE_SELECT_LSB) |
                         (16'(pll_lock) << OSC_LOCK_BIT) |
                         (16'(cf_reg) << OSC_CF_BIT) |
                         (16'(swr_reg) << OSC_SWR_BIT);
  wire [15:0] div_view = (16'(roi_reg) << DIV_ROI_BIT) |
                         (16'(doze_reg) << DIV_DOZE_LSB) |
                         (16'(doze_enable_reg) << DIV_DOZE_ENABLE_BIT) |
                         (16'(frc_reg) << DIV_FRC_LSB) |
                         (16'(pre_reg) << DIV_PRE_LSB);
  wire [15:0] pdiv_view = (16'(vco_reg) << PDIV_VCO_LSB) |
                          (16'(p1_reg) << PDIV_P1_LSB) |
                          (16'(p2_reg) << PDIV_P2_LSB);
  wire [15:0] rd_view = hit_osc  ? osc_view :
                        hit_div  ? div_view :
                        hit_fbd  ? 16'(fbd_reg) :
                        hit_tun  ? 16'(tun_reg) :
                        hit_pdiv ? pdiv_view : 16'h0000;

  // apb answer: one access cycle, no waits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata  <= pwrite ? 32'h0000_0000 : 32'(rd_view);
        pslverr <= ~mapped;
      end
    end
  end

  // oscillator control
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cf_reg     <= 1'b0;
      trap_reg   <= 1'b0;
      swr_reg    <= 1'b0;
      new_source_select_reg   <= SRC_RST;
      target_reg <= SRC_RST;
      current_source_select_reg   <= SRC_RST;
    end else if (clk_en) begin
      cf_reg     <= cf_next;
      trap_reg   <= trap_next;
      swr_reg    <= swr_next;
      new_source_select_reg   <= new_source_select_next;
      target_reg <= scd_map_source(new_source_select_next);
      current_source_select_reg   <= current_source_select_next;
    end
  end

  // clock divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      roi_reg   <= 1'b0;
      doze_reg  <= DOZE_RST;
      doze_enable_reg <= 1'b0;
      ratio_reg <= DOZE_1TO1;
      frc_reg   <= FRC_RST;
      pre_reg   <= PRE_RST;
    end else if (clk_en) begin
      roi_reg   <= roi_next;
      doze_reg  <= doze_next;
      doze_enable_reg <= doze_enable_next;
      ratio_reg <= ratio_next;
      frc_reg   <= frc_next;
      pre_reg   <= pre_next;
    end
  end

  // pll feedback, trim and output dividers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fbd_reg <= FBD_RST;
      tun_reg <= TUN_RST;
      vco_reg <= VCO_RST;
      p1_reg  <= P1_RST;
      p2_reg  <= P2_RST;
    end else if (clk_en) begin
      if (fbd_wr) begin
        fbd_reg <= pwdata[BYTE_W-1:0];
      end
      if (tun_wr) begin
        tun_reg <= pwdata[5:0];
      end
      if (pdiv_wr_hi) begin
        vco_reg <= pwdata[PDIV_VCO_LSB +: 2];
      end
      if (pdiv_wr_lo) begin
        p1_reg <= pwdata[PDIV_P1_LSB +: 3];
        p2_reg <= pwdata[PDIV_P2_LSB +: 3];
      end
    end
  end

  assign clock_fail_flag       = cf_reg;
  assign fail_trap             = trap_reg;
  assign switch_request        = swr_reg;
  assign new_source_select     = target_reg;
  assign current_source_select = current_source_select_reg;
  assign doze_enable           = doze_enable_reg;
  assign doze_ratio            = ratio_reg;
  assign fast_rc_postscaler    = frc_reg;
  assign pll_prescaler         = pre_reg;
  assign pll_feedback_value    = fbd_reg;
  assign fast_rc_trim          = tun_reg;
  assign vco_output_divider    = vco_reg;
  assign first_post_divider    = p1_reg;
  assign second_post_divider   = p2_reg;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  fail_sets_a: assert property (
    clk_en && monitor_fail |=> cf_reg && fail_trap)
    else $error("clock failure did not set flag and trap");

  sw_trap_a: assert property (
    clk_en && osc_apply[LANE_LO] && pwdata[OSC_CF_BIT] |=> fail_trap ##1 !fail_trap
      || $past(monitor_fail) || $past(sw_cf_set))
    else $error("software fail write did not pulse trap");

  switch_end_a: assert property (
    clk_en && swr_reg && switch_done && !sw_swr_set
      |=> !swr_reg && current_source_select == scd_map_source($past(new_source_select_reg)))
    else $error("switch completion wrong");

  locked_osc_a: assert property (
    clk_en && osc_lane_wr[LANE_HI] && !lane_open[LANE_HI] |=> $stable(new_source_select_reg))
    else $error("locked oscillator write took effect");

  no_reserved_a: assert property (
    new_source_select != SRC_RSVD && current_source_select != SRC_RSVD)
    else $error("reserved source code driven");

  roi_recover_a: assert property (
    clk_en && irq_any && roi_reg |=> !doze_enable && doze_ratio == DOZE_1TO1)
    else $error("interrupt did not recover doze");

  ratio_sel_a: assert property (
    doze_ratio == (doze_enable ? doze_reg : DOZE_1TO1))
    else $error("doze ratio mismatch");

  doze_frozen_a: assert property (
    clk_en && doze_enable_reg |=> doze_reg == $past(doze_reg))
    else $error("doze field changed while enabled");

  doze_zero_a: assert property (
    !(doze_enable && doze_reg == DOZE_1TO1))
    else $error("doze enabled with zero ratio");

  pll_reset_a: assert property (
    $fell(sys_rst) |-> first_post_divider == P1_RST && second_post_divider == P2_RST
      && pll_feedback_value == FBD_RST)
    else $error("pll dividers wrong after reset");

  wire [3:0] pre_field = pwdata[DIV_PRE_LSB +: 4];
  wire [7:0] fbd_field = pwdata[BYTE_W-1:0];

  cf_quiet_a: assert property (
    clk_en && !cf_reg && !monitor_fail && !sw_cf_set |=> !clock_fail_flag)
    else $error("clock-fail flag set with no failure");

  cf_sticky_a: assert property (
    clk_en && cf_reg && !osc_apply[LANE_LO] |=> clock_fail_flag)
    else $error("clock-fail flag lost without a write");

  trap_quiet_a: assert property (
    clk_en && !monitor_fail && !sw_cf_set |=> !fail_trap)
    else $error("failure trap without a failure");

  switch_start_a: assert property (
    clk_en && osc_apply[LANE_LO] && pwdata[OSC_SWR_BIT] |=> switch_request)
    else $error("switch request not taken");

  switch_hold_a: assert property (
    clk_en && swr_reg && !switch_done |=> switch_request)
    else $error("switch request dropped early");

  doze_keep_a: assert property (
    clk_en && !roi_reg && doze_enable_reg && !div_wr_hi |=> doze_enable)
    else $error("doze enable lost without recovery");

  div_reset_a: assert property (
    $fell(sys_rst) |-> doze_reg == DOZE_RST && fast_rc_postscaler == FRC_RST
      && pll_prescaler == PRE_RST && vco_output_divider == VCO_RST)
    else $error("divider fields wrong after reset");

  pre_apply_a: assert property (
    clk_en && div_wr_lo |=> pll_prescaler == $past(pre_field))
    else $error("prescaler write not applied at once");

  fbd_apply_a: assert property (
    clk_en && fbd_wr |=> pll_feedback_value == $past(fbd_field))
    else $error("feedback divider write lost");

endmodule : scd_clock_control

// ==== core/scd_pkg.sv ====
package scd_pkg;

  // register byte addresses
  localparam logic [7:0] OSC_ADDR  = 8'h00;
  localparam logic [7:0] DIV_ADDR  = 8'h04;
  localparam logic [7:0] FBD_ADDR  = 8'h08;
  localparam logic [7:0] TUN_ADDR  = 8'h0c;
  localparam logic [7:0] PDIV_ADDR = 8'h10;

  // byte lanes of the 16-bit registers
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam int LANES   = 2;

  // unlock keys, index 0 low byte, index 1 high byte
  localparam logic [1:0][7:0] KEY_FIRST  = {8'h78, 8'h46};
  localparam logic [1:0][7:0] KEY_SECOND = {8'h9a, 8'h57};

  // field positions
  localparam int OSC_CURRENT_SOURCE_SELECT_LSB  = 12;
  localparam int OSC_NEW_SOURCE_SELECT_LSB  = 8;
  localparam int OSC_LOCK_BIT  = 5;
  localparam int OSC_CF_BIT    = 3;
  localparam int OSC_SWR_BIT   = 0;
  localparam int DIV_ROI_BIT   = 15;
  localparam int DIV_DOZE_LSB  = 12;
  localparam int DIV_DOZE_ENABLE_BIT = 11;
  localparam int DIV_FRC_LSB   = 8;
  localparam int DIV_PRE_LSB   = 0;
  localparam int PDIV_VCO_LSB  = 8;
  localparam int PDIV_P1_LSB   = 4;
  localparam int PDIV_P2_LSB   = 0;
  localparam int BYTE_W        = 8;

  // source codes and reset values
  localparam logic [2:0] SRC_FRC   = 3'h0;
  localparam logic [2:0] SRC_RSVD  = 3'h4;
  localparam logic [2:0] SRC_RST   = 3'h7;
  localparam logic [2:0] DOZE_RST  = 3'h3;
  localparam logic [2:0] DOZE_1TO1 = 3'h0;
  localparam logic [2:0] FRC_RST   = 3'h0;
  localparam logic [3:0] PRE_RST   = 4'h1;
  localparam logic [7:0] FBD_RST   = 8'h96;
  localparam logic [5:0] TUN_RST   = 6'h00;
  localparam logic [1:0] VCO_RST   = 2'h0;
  localparam logic [2:0] P1_RST    = 3'h4;
  localparam logic [2:0] P2_RST    = 3'h1;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_ARMED,
    UNL_OPEN
  } scd_unlock_state_t;

  // reserved source code falls back to fast rc
  function automatic logic [2:0] scd_map_source(input logic [2:0] code);
    scd_map_source = (code == SRC_RSVD) ? SRC_FRC : code;
  endfunction : scd_map_source

endpackage : scd_pkg

// ==== core/scd_unlock.sv ====
`timescale 1ns/10ps
module scd_unlock
  import scd_pkg::*;
#(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // bus events
  input  wire logic       lane_wr,
  input  wire logic       other_acc,
  input  wire logic [7:0] wr_byte,
  // one write may pass
  output logic            open
);

  scd_unlock_state_t state_reg;
  scd_unlock_state_t state_next;

  // any other access breaks the back-to-back sequence
  always_comb begin
    state_next = state_reg;
    if (other_acc) begin
      state_next = UNL_IDLE;
    end else if (lane_wr) begin
      unique case (state_reg)
        UNL_OPEN: begin
          state_next = UNL_IDLE;
        end
        UNL_ARMED: begin
          state_next = (wr_byte == KEY2) ? UNL_OPEN :
                       (wr_byte == KEY1) ? UNL_ARMED : UNL_IDLE;
        end
        UNL_IDLE: begin
          state_next = (wr_byte == KEY1) ? UNL_ARMED : UNL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= UNL_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign open = (state_reg == UNL_OPEN);

endmodule : scd_unlock

// ==== tb/test_scd_clock_control.sv ====
`timescale 1ns/10ps
module test_scd_clock_control
  import scd_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        monitor_fail = 1'b0;
  logic        switch_done = 1'b0;
  logic        irq_any = 1'b0;
  logic        pll_lock = 1'b1;
  logic        clk_en = 1'b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, clock_fail_flag, fail_trap, switch_request, doze_enable;
  wire  [2:0]  new_source_select, current_source_select, doze_ratio, fast_rc_postscaler;
  wire  [2:0]  first_post_divider, second_post_divider;
  wire  [3:0]  pll_prescaler;
  wire  [7:0]  pll_feedback_value;
  wire  [5:0]  fast_rc_trim;
  wire  [1:0]  vco_output_divider;
  logic [31:0] rdata;
  logic        rerr;
  int          n_fail = 0;
  int          checked = 0;

  always #2.5 clk = ~clk;

  scd_clock_control i_scd_clock_control (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_fail(monitor_fail), .switch_done(switch_done), .irq_any(irq_any),
    .pll_lock(pll_lock), .clock_fail_flag(clock_fail_flag), .fail_trap(fail_trap),
    .switch_request(switch_request), .new_source_select(new_source_select),
    .current_source_select(current_source_select), .doze_enable(doze_enable),
    .doze_ratio(doze_ratio), .fast_rc_postscaler(fast_rc_postscaler),
    .pll_prescaler(pll_prescaler), .pll_feedback_value(pll_feedback_value),
    .fast_rc_trim(fast_rc_trim), .vco_output_divider(vco_output_divider),
    .first_post_divider(first_post_divider), .second_post_divider(second_post_divider));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // setup, access until pready, then release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let the access edge settle before callers look at outputs
    @(negedge clk);
  endtask : apb

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, exp, rdata);
  endtask : rdchk

  // key pair then one guarded write on one byte lane
  task osc_wr(input logic hi, input logic [7:0] v);
    logic [3:0] s;
    int         sh;
    s  = hi ? 4'h2 : 4'h1;
    sh = hi ? 8 : 0;
    apb(1'b1, OSC_ADDR, 32'(hi ? 8'h78 : 8'h46) << sh, s);
    apb(1'b1, OSC_ADDR, 32'(hi ? 8'h9a : 8'h57) << sh, s);
    apb(1'b1, OSC_ADDR, 32'(v) << sh, s);
  endtask : osc_wr

  task nclk(input int n);
    repeat (n) @(negedge clk);
  endtask : nclk

  task finish_test();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100us;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("osc reset", OSC_ADDR, 32'h7720);
    rdchk("div reset", DIV_ADDR, 32'h3001);
    rdchk("fbd reset", FBD_ADDR, 32'h0096);
    rdchk("tun reset", TUN_ADDR, 32'h0000);
    rdchk("pdiv reset", PDIV_ADDR, 32'h0041);
    chk("postscaler reset", 32'(fast_rc_postscaler), 32'h0);
    chk("vco reset", 32'(vco_output_divider), 32'h0);
    rdchk("unmapped read", 8'h14, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    $display("reset test done");

    apb(1'b1, OSC_ADDR, 32'h0100, 4'h2);
    rdchk("osc locked", OSC_ADDR, 32'h7720);
    osc_wr(1'b1, 8'h04);
    chk("reserved source", 32'(new_source_select), 32'h0);
    osc_wr(1'b1, 8'h03);
    chk("new source", 32'(new_source_select), 32'h3);
    osc_wr(1'b0, 8'h01);
    nclk(2);
    chk("switch pending", 32'(switch_request), 32'h1);
    chk("cur before", 32'(current_source_select), 32'h7);
    @(posedge clk) switch_done <= 1'b1;
    @(posedge clk) switch_done <= 1'b0;
    nclk(1);
    chk("switch done", 32'(switch_request), 32'h0);
    chk("cur after", 32'(current_source_select), 32'h3);
    rdchk("osc switched", OSC_ADDR, 32'h3320);
    osc_wr(1'b0, 8'h08);
    chk("sw trap", 32'(fail_trap), 32'h1);
    chk("sw flag", 32'(clock_fail_flag), 32'h1);
    nclk(1);
    chk("sw trap end", 32'(fail_trap), 32'h0);
    osc_wr(1'b0, 8'h00);
    nclk(1);
    chk("flag cleared", 32'(clock_fail_flag), 32'h0);
    @(posedge clk) monitor_fail <= 1'b1;
    @(posedge clk) monitor_fail <= 1'b0;
    nclk(1);
    chk("mon trap", 32'(fail_trap), 32'h1);
    chk("mon flag", 32'(clock_fail_flag), 32'h1);
    osc_wr(1'b0, 8'h00);
    $display("oscillator test done");

    apb(1'b1, DIV_ADDR, 32'h5008, 4'h3);
    chk("ratio doze off", 32'(doze_ratio), 32'h0);
    chk("prescaler", 32'(pll_prescaler), 32'h8);
    apb(1'b1, DIV_ADDR, 32'h5808, 4'h3);
    chk("ratio doze on", 32'(doze_ratio), 32'h5);
    apb(1'b1, DIV_ADDR, 32'h2808, 4'h3);
    rdchk("doze frozen", DIV_ADDR, 32'h5808);
    apb(1'b1, DIV_ADDR, 32'hd808, 4'h3);
    @(posedge clk) irq_any <= 1'b1;
    @(posedge clk) irq_any <= 1'b0;
    nclk(2);
    chk("roi enable", 32'(doze_enable), 32'h0);
    chk("roi ratio", 32'(doze_ratio), 32'h0);
    apb(1'b1, DIV_ADDR, 32'h5808, 4'h3);
    @(posedge clk) irq_any <= 1'b1;
    @(posedge clk) irq_any <= 1'b0;
    nclk(2);
    chk("no roi", 32'(doze_enable), 32'h1);
    apb(1'b1, DIV_ADDR, 32'h0000, 4'h3);
    apb(1'b1, DIV_ADDR, 32'h0000, 4'h3);
    apb(1'b1, DIV_ADDR, 32'h0800, 4'h3);
    rdchk("doze zero refuse", DIV_ADDR, 32'h0000);
    apb(1'b1, DIV_ADDR, 32'h0700, 4'h3);
    chk("postscaler", 32'(fast_rc_postscaler), 32'h7);
    $display("divider test done");

    osc_wr(1'b1, 8'h00);
    osc_wr(1'b0, 8'h01);
    @(posedge clk) switch_done <= 1'b1;
    @(posedge clk) switch_done <= 1'b0;
    nclk(1);
    chk("cur fast rc", 32'(current_source_select), 32'h0);
    apb(1'b1, FBD_ADDR, 32'h00c8, 4'h3);
    chk("feedback", 32'(pll_feedback_value), 32'hc8);
    apb(1'b1, TUN_ADDR, 32'hffff_ffe0, 4'h3);
    rdchk("trim", TUN_ADDR, 32'h0020);
    chk("trim port", 32'(fast_rc_trim), 32'h20);
    apb(1'b1, PDIV_ADDR, 32'h0371, 4'h3);
    rdchk("pdiv", PDIV_ADDR, 32'h0371);
    chk("post1", 32'(first_post_divider), 32'h7);
    chk("post2", 32'(second_post_divider), 32'h1);
    apb(1'b1, 8'h14, 32'h0011, 4'h3);
    chk("unmapped werr", 32'(rerr), 32'h1);
    rdchk("fbd kept", FBD_ADDR, 32'h00c8);
    @(posedge clk);
    clk_en       <= 1'b0;
    monitor_fail <= 1'b1;
    nclk(2);
    chk("frozen flag", 32'(clock_fail_flag), 32'h0);
    chk("frozen trap", 32'(fail_trap), 32'h0);
    @(posedge clk);
    monitor_fail <= 1'b0;
    clk_en       <= 1'b1;
    nclk(1);
    chk("thawed flag", 32'(clock_fail_flag), 32'h0);
    $display("pll test done");
    finish_test();
  end
endmodule : test_scd_clock_control
